// ---- design/fbm_pkg.sv ----
// shared constants and types for the flash block map and command sequencer
package fbm_pkg;

  localparam int ADDR_W  = 20;
  localparam int DATA_W  = 16;
  localparam int NUM_BLK = 8;
  localparam int BLK_W   = 3;

  // boot area, 8 Kbytes
  localparam logic [ADDR_W-1:0] BOOT_LO = 20'h7_E000;
  localparam logic [ADDR_W-1:0] BOOT_HI = 20'h7_FFFF;

  // user blocks 1..8 at index 0..7; 0x80000..0xBFFFF decodes to nothing
  localparam logic [ADDR_W-1:0] BLK_LO [NUM_BLK] = '{
    20'hF_F000, 20'hF_E000, 20'hF_8000, 20'hF_0000,
    20'hE_0000, 20'hD_0000, 20'hC_0000, 20'h7_D000};
  localparam logic [ADDR_W-1:0] BLK_HI [NUM_BLK] = '{
    20'hF_FFFF, 20'hF_EFFF, 20'hF_DFFF, 20'hF_7FFF,
    20'hE_FFFF, 20'hD_FFFF, 20'hC_FFFF, 20'h7_DFFF};

  // command codes, low data byte only
  localparam logic [7:0] CMD_READ  = 8'hFF;
  localparam logic [7:0] CMD_STAT  = 8'h70;
  localparam logic [7:0] CMD_CLR   = 8'h50;
  localparam logic [7:0] CMD_PROG  = 8'h40;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_LOCK  = 8'h77;
  localparam logic [7:0] CMD_CONF  = 8'hD0;

  // status byte field positions
  localparam int SR_RDY = 7;
  localparam int SR_ERS = 5;
  localparam int SR_PRG = 4;

  // command source: the three flash operating modes
  localparam logic [1:0] SRC_CPU = 2'h0;
  localparam logic [1:0] SRC_PAR = 2'h1;
  localparam logic [1:0] SRC_SER = 2'h2;

  typedef enum logic [1:0] {START_NORMAL, START_BOOT, START_PROG} fbm_start_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ARG, ST_RUN} fbm_st_t;

endpackage

// ---- design/fbm_dec_if.sv ----
// carrier between the sequencer and the block address decoder
`timescale 1ns/1ps
`default_nettype none
interface fbm_dec_if;
  import fbm_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic              hit;
  logic              boot;
  logic [BLK_W-1:0]  blk;
  logic              top_even;

  modport req (output addr, input hit, boot, blk, top_even);
  modport dec (input addr, output hit, boot, blk, top_even);
endinterface
`default_nettype wire

// ---- design/fbm_blk_dec.sv ----
// decodes a flash address into user block, boot area or no block
`timescale 1ns/1ps
`default_nettype none
module fbm_blk_dec (
  fbm_dec_if.dec dec
);
  import fbm_pkg::*;

  always_comb begin
    dec.hit      = 1'b0;
    dec.boot     = 1'b0;
    dec.blk      = '0;
    dec.top_even = 1'b0;
    if (dec.addr >= BOOT_LO && dec.addr <= BOOT_HI) begin
      dec.hit      = 1'b1;
      dec.boot     = 1'b1;
      dec.top_even = (dec.addr == {BOOT_HI[ADDR_W-1:1], 1'b0});
    end
    for (int i = 0; i < NUM_BLK; i++) begin
      if (dec.addr >= BLK_LO[i] && dec.addr <= BLK_HI[i]) begin
        dec.hit      = 1'b1;
        dec.blk      = BLK_W'(i);
        dec.top_even = (dec.addr == {BLK_HI[i][ADDR_W-1:1], 1'b0});
      end
    end
  end

endmodule
`default_nettype wire

// ---- design/fbm_ctl.sv ----
// flash block map, lock protection, rewrite mode and start-up mode control
// What this block does
// - three modes: parallel, serial, CPU rewrite
// - erase touches exactly one block
// - locked block refuses program and erase
// - boot area rewritable only from parallel mode
// - 8-Kbyte boot area at 0x7E000-0x7FFFF
// - blocks 7,6,5 64K; block 4 32K
// - CPU rewrite modifies user area only
// - no flash reads during rewrite mode
// - select pin low: normal start
// - both pins high: boot start
// - boot rewrite ends factory serial programming
// - erase block named by top even address
// - rewrite select needs zero then one
// - ready flag low while programming or erasing
// - odd-address commands are ignored
// - only low command byte decoded
`timescale 1ns/1ps
`default_nettype none
module fbm_ctl (
  input  wire logic                            clk_sys_in,
  input  wire logic                            sys_rst_in,
  input  wire logic                            boot_select_pin_in,
  input  wire logic                            boot_qualifier_pin_in,
  input  wire logic                            boot_factory_in,
  input  wire logic                            sel_wr_in,
  input  wire logic                            sel_data_in,
  input  wire logic                            lock_clr_all_in,
  input  wire logic                            cmd_wr_in,
  input  wire logic [1:0]                      cmd_src_in,
  input  wire logic [fbm_pkg::ADDR_W-1:0]      cmd_addr_in,
  input  wire logic [fbm_pkg::DATA_W-1:0]      cmd_data_in,
  input  wire logic                            rd_req_in,
  input  wire logic                            arr_done_in,
  output fbm_pkg::fbm_start_t                  start_mode_out,
  output logic                                 rewrite_mode_out,
  output logic                                 flash_ready_flag_out,
  output logic [7:0]                           status_out,
  output logic                                 status_sel_out,
  output logic [fbm_pkg::NUM_BLK-1:0]          locks_out,
  output logic                                 rd_grant_out,
  output logic                                 rd_refused_out,
  output logic                                 serial_prog_avail_out,
  output logic                                 arr_start_out,
  output logic                                 arr_erase_out,
  output logic                                 arr_boot_out,
  output logic [fbm_pkg::BLK_W-1:0]            arr_blk_out,
  output logic [fbm_pkg::ADDR_W-1:0]           arr_addr_out,
  output logic [fbm_pkg::DATA_W-1:0]           arr_data_out
);
  import fbm_pkg::*;

  typedef struct packed {
    fbm_st_t           st;
    logic [7:0]        pend;
    logic              rw_sel;
    logic              last_zero;
    logic              started;
    fbm_start_t        start_mode;
    logic [NUM_BLK-1:0] locks;
    logic              prog_err;
    logic              erase_err;
    logic              stat_sel;
    logic              boot_touched;
    logic              arr_start;
    logic              arr_erase;
    logic              arr_boot;
    logic [1:0]        arr_src;
    logic [BLK_W-1:0]  arr_blk;
    logic [ADDR_W-1:0] arr_addr;
    logic [DATA_W-1:0] arr_data;
  } fbm_ctl_state_t;

  localparam fbm_ctl_state_t RST_STATE = '{
    st: ST_IDLE, pend: 8'h00, start_mode: START_NORMAL, arr_src: SRC_CPU,
    default: '0};

  fbm_ctl_state_t s_q;
  fbm_ctl_state_t s_d;
  fbm_dec_if      dec_if ();
  logic [7:0]     code;
  logic           cmd_ok;
  logic           legal;
  logic           locked;

  fbm_blk_dec u_dec (
    .dec (dec_if.dec)
  );

  assign dec_if.addr = cmd_addr_in;
  assign code        = cmd_data_in[7:0];
  // odd addresses drop out; the CPU path needs rewrite mode active
  assign cmd_ok = cmd_wr_in && !cmd_addr_in[0]
                  && (cmd_src_in != SRC_CPU || s_q.rw_sel);
  // boot area only from the parallel programmer
  assign legal  = dec_if.hit && (!dec_if.boot || cmd_src_in == SRC_PAR);
  assign locked = !dec_if.boot && s_q.locks[dec_if.blk];

  always_comb begin
    s_d           = s_q;
    s_d.arr_start = 1'b0;
    if (!s_q.started) begin
      s_d.started = 1'b1;
      if (!boot_select_pin_in) begin
        s_d.start_mode = START_NORMAL;
      end else if (boot_qualifier_pin_in) begin
        s_d.start_mode = START_BOOT;
      end else begin
        s_d.start_mode = START_PROG;
      end
    end
    if (sel_wr_in) begin
      if (!sel_data_in) begin
        s_d.rw_sel    = 1'b0;
        s_d.last_zero = 1'b1;
      end else begin
        if (s_q.last_zero) begin
          s_d.rw_sel = 1'b1;
        end
        s_d.last_zero = 1'b0;
      end
    end
    if (lock_clr_all_in) begin
      s_d.locks = '0;
    end
    case (s_q.st)
      ST_IDLE: begin
        if (cmd_ok) begin
          case (code)
            CMD_READ: s_d.stat_sel = 1'b0;
            CMD_STAT: s_d.stat_sel = 1'b1;
            CMD_CLR: begin
              s_d.prog_err  = 1'b0;
              s_d.erase_err = 1'b0;
            end
            CMD_PROG, CMD_ERASE, CMD_LOCK: begin
              s_d.pend     = code;
              s_d.stat_sel = 1'b1;
              s_d.st       = ST_ARG;
            end
            default: s_d.pend = s_q.pend;
          endcase
        end
      end
      ST_ARG: begin
        if (cmd_ok) begin
          s_d.st = ST_IDLE;
          case (s_q.pend)
            CMD_PROG: begin
              if (legal && !locked) begin
                s_d.arr_start = 1'b1;
                s_d.arr_erase = 1'b0;
                s_d.st        = ST_RUN;
              end else begin
                s_d.prog_err = 1'b1;
              end
            end
            CMD_ERASE: begin
              if (code == CMD_CONF && dec_if.top_even && legal && !locked) begin
                s_d.arr_start = 1'b1;
                s_d.arr_erase = 1'b1;
                s_d.st        = ST_RUN;
              end else begin
                s_d.erase_err = 1'b1;
              end
            end
            default: begin
              if (code == CMD_CONF && dec_if.top_even && dec_if.hit && !dec_if.boot) begin
                s_d.locks[dec_if.blk] = 1'b1;
              end else begin
                s_d.prog_err = 1'b1;
              end
            end
          endcase
          if (s_d.arr_start) begin
            s_d.arr_boot     = dec_if.boot;
            s_d.arr_src      = cmd_src_in;
            s_d.arr_blk      = dec_if.blk;
            s_d.arr_addr     = cmd_addr_in;
            s_d.arr_data     = cmd_data_in;
            s_d.boot_touched = s_q.boot_touched | dec_if.boot;
          end
        end
      end
      ST_RUN: begin
        if (arr_done_in) begin
          s_d.st = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign start_mode_out        = s_q.start_mode;
  assign rewrite_mode_out      = s_q.rw_sel;
  assign flash_ready_flag_out  = (s_q.st != ST_RUN);
  assign status_out            = {flash_ready_flag_out, 1'b0, s_q.erase_err, s_q.prog_err, 4'h0};
  assign status_sel_out        = s_q.stat_sel;
  assign locks_out             = s_q.locks;
  assign rd_grant_out          = rd_req_in && !s_q.rw_sel;
  assign rd_refused_out        = rd_req_in && s_q.rw_sel;
  assign serial_prog_avail_out = boot_factory_in && !s_q.boot_touched;
  assign arr_start_out         = s_q.arr_start;
  assign arr_erase_out         = s_q.arr_erase;
  assign arr_boot_out          = s_q.arr_boot;
  assign arr_blk_out           = s_q.arr_blk;
  assign arr_addr_out          = s_q.arr_addr;
  assign arr_data_out          = s_q.arr_data;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  sequence zero_write;
    sel_wr_in && !sel_data_in;
  endsequence
  sequence one_write;
    sel_wr_in && sel_data_in;
  endsequence

  a_sel_pair_sets: assert property (zero_write ##1 one_write |=> rewrite_mode_out)
    else $error("zero then one did not set rewrite select");
  a_sel_lone_one: assert property (sel_wr_in && sel_data_in && !s_q.last_zero
                                   && !s_q.rw_sel |=> !rewrite_mode_out)
    else $error("lone one write set rewrite select");
  a_busy_after_go: assert property (arr_start_out |-> !flash_ready_flag_out
                                    ##1 (!flash_ready_flag_out || $past(arr_done_in)))
    else $error("ready flag high during array operation");
  a_odd_cmd_drop: assert property (s_q.st == ST_IDLE && cmd_wr_in && cmd_addr_in[0]
                                   |=> s_q.st == ST_IDLE && $stable(s_q.stat_sel))
    else $error("odd address command was taken");
  a_no_read_rw: assert property (rewrite_mode_out |-> !rd_grant_out && (rd_req_in == rd_refused_out))
    else $error("flash read granted in rewrite mode");
  a_lock_guard: assert property (arr_start_out && !arr_boot_out |-> !locks_out[arr_blk_out])
    else $error("array operation started on locked block");
  a_boot_guard: assert property (arr_start_out && arr_boot_out |-> s_q.arr_src == SRC_PAR)
    else $error("boot area rewrite outside parallel mode");
  a_boot_start: assert property (!s_q.started && boot_select_pin_in
                                 && boot_qualifier_pin_in |=> start_mode_out == START_BOOT)
    else $error("boot start not selected");
  a_norm_start: assert property (!s_q.started && !boot_select_pin_in
                                 |=> start_mode_out == START_NORMAL)
    else $error("normal start not selected");
  a_mode_held: assert property (s_q.started |=> $stable(start_mode_out))
    else $error("start mode changed before reset");
  a_bad_erase: assert property (s_q.st == ST_ARG && s_q.pend == CMD_ERASE && cmd_ok
                                && !dec_if.top_even |=> s_q.erase_err && !arr_start_out)
    else $error("erase accepted at non top address");

endmodule
`default_nettype wire

// ---- sim/fbm_arr_model.sv ----
// flash array partner: answers each started operation with a done pulse
`timescale 1ns/1ps
`default_nettype none
module fbm_arr_model #(
  parameter int DLY = 3
) (
  input  wire logic clk_sys_in,
  input  wire logic arr_start_in,
  output logic      arr_done_out
);
  int cnt = 0;
  initial arr_done_out = 1'b0;
  // done comes only for a started operation, a few cycles later
  always @(negedge clk_sys_in) begin
    arr_done_out <= 1'b0;
    if (arr_start_in) begin
      cnt = DLY;
    end else if (cnt > 0) begin
      cnt = cnt - 1;
      if (cnt == 0) arr_done_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- sim/fbm_ctl_tb_top.sv ----
// self-checking bench for the flash block map and command sequencer
`timescale 1ns/1ps
`default_nettype none
module fbm_ctl_tb_top;
  import fbm_pkg::*;
  logic               clk_sys_in, sys_rst_in, bs, bq, bf, sel_wr, sel_d, lclr, wr, rd, done;
  logic [1:0]         src;
  logic [ADDR_W-1:0]  addr, aaddr;
  logic [DATA_W-1:0]  data, adata;
  fbm_start_t         smode;
  logic               rw, rdy, ssel, grant, refused, spa, st, er, bt;
  logic [7:0]         stat;
  logic [NUM_BLK-1:0] locks;
  logic [BLK_W-1:0]   blk;
  logic [ADDR_W-1:0]  top [NUM_BLK];
  int                 mismatches = 0;
  int                 cmp_count = 0;

  fbm_ctl i_fbm_ctl (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .boot_select_pin_in(bs), .boot_qualifier_pin_in(bq), .boot_factory_in(bf),
    .sel_wr_in(sel_wr), .sel_data_in(sel_d), .lock_clr_all_in(lclr), .cmd_wr_in(wr),
    .cmd_src_in(src), .cmd_addr_in(addr), .cmd_data_in(data), .rd_req_in(rd),
    .arr_done_in(done), .start_mode_out(smode), .rewrite_mode_out(rw),
    .flash_ready_flag_out(rdy), .status_out(stat), .status_sel_out(ssel),
    .locks_out(locks), .rd_grant_out(grant), .rd_refused_out(refused),
    .serial_prog_avail_out(spa), .arr_start_out(st), .arr_erase_out(er),
    .arr_boot_out(bt), .arr_blk_out(blk), .arr_addr_out(aaddr), .arr_data_out(adata));
  fbm_arr_model i_fbm_arr_model (.clk_sys_in(clk_sys_in), .arr_start_in(st),
    .arr_done_out(done));

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic rst(input logic s, input logic q);
    bs = s;
    bq = q;
    sys_rst_in = 1'b1;
    repeat (12) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    @(negedge clk_sys_in);
    bs = ~s;
    bq = ~q;
    @(negedge clk_sys_in);
  endtask

  task automatic sel(input logic v);
    sel_d = v;
    sel_wr = 1'b1;
    @(negedge clk_sys_in);
    sel_wr = 1'b0;
    @(negedge clk_sys_in);
  endtask

  task automatic op1(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] c);
    src = SRC_CPU;
    addr = a;
    data = c;
    wr = 1'b1;
    @(negedge clk_sys_in);
    wr = 1'b0;
    @(negedge clk_sys_in);
  endtask

  // code word then argument word, start checked in the cycle after the argument
  task automatic op2(input logic [1:0] s, input logic [15:0] c, input logic [ADDR_W-1:0] a,
                     input logic [15:0] d, input logic go);
    int n;
    src = s;
    addr = 20'h0_0000;
    data = c;
    wr = 1'b1;
    @(negedge clk_sys_in);
    addr = a;
    data = d;
    @(negedge clk_sys_in);
    wr = 1'b0;
    chk("arr_start", st, go);
    chk("ready", rdy, !go);
    n = 0;
    while (rdy !== 1'b1 && n < 50) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk("ready", rdy, 1'b1);
    @(negedge clk_sys_in);
  endtask

  initial begin
    {sys_rst_in, bs, bq, sel_wr, sel_d, lclr, wr, rd} = '0;
    bf = 1'b1;
    src = SRC_CPU;
    addr = '0;
    data = '0;
    top = '{20'hF_FFFE, 20'hF_EFFE, 20'hF_DFFE, 20'hF_7FFE,
            20'hE_FFFE, 20'hD_FFFE, 20'hC_FFFE, 20'h7_DFFE};
    rst(1'b1, 1'b1);
    chk("start_mode", smode, START_BOOT);
    rst(1'b1, 1'b0);
    chk("start_mode", smode, START_PROG);
    rst(1'b0, 1'b1);
    chk("start_mode", smode, START_NORMAL);
    chk("status", stat, 8'h80);
    chk("locks", locks, 8'h00);
    rd = 1'b1;
    @(negedge clk_sys_in);
    chk("grant", grant, 1'b1);
    op2(SRC_CPU, 16'h0020, 20'hE_FFFE, 16'h00D0, 1'b0);
    sel(1'b1);
    chk("rewrite", rw, 1'b0);
    sel(1'b0);
    sel(1'b1);
    chk("rewrite", rw, 1'b1);
    chk("grant", grant, 1'b0);
    chk("refused", refused, 1'b1);
    rd = 1'b0;
    for (int i = 0; i < NUM_BLK; i++) begin
      op2(SRC_CPU, 16'hAB20, top[i], 16'h55D0, 1'b1);
      chk("blk", blk, i);
      chk("erase", er, 1'b1);
    end
    op2(SRC_CPU, 16'h0020, 20'hE_FFFC, 16'h00D0, 1'b0);
    chk("status", stat, 8'hA0);
    op1(20'h0_0000, 16'h0050);
    op2(SRC_CPU, 16'h0020, 20'hB_FFFE, 16'h00D0, 1'b0);
    op1(20'h0_0000, 16'h0050);
    op1(20'hE_0001, 16'h0020);
    op1(20'hE_FFFE, 16'h00D0);
    chk("blk", blk, 7);
    chk("status", stat, 8'h80);
    op2(SRC_CPU, 16'h0040, 20'hD_1234, 16'hBEEF, 1'b1);
    chk("erase", er, 1'b0);
    chk("arr_addr", aaddr, 20'hD_1234);
    chk("arr_data", adata, 16'hBEEF);
    op2(SRC_CPU, 16'h0077, 20'hD_FFFE, 16'h00D0, 1'b0);
    chk("locks", locks, 8'h20);
    op2(SRC_CPU, 16'h0020, 20'hD_FFFE, 16'h00D0, 1'b0);
    chk("status", stat, 8'hA0);
    op1(20'h0_0000, 16'h0050);
    op2(SRC_CPU, 16'h0040, 20'hD_0010, 16'h1111, 1'b0);
    chk("status", stat, 8'h90);
    op1(20'h0_0000, 16'h0050);
    lclr = 1'b1;
    @(negedge clk_sys_in);
    lclr = 1'b0;
    @(negedge clk_sys_in);
    chk("locks", locks, 8'h00);
    op2(SRC_CPU, 16'h0020, 20'hD_FFFE, 16'h00D0, 1'b1);
    chk("serial_avail", spa, 1'b1);
    op2(SRC_CPU, 16'h0020, 20'h7_FFFE, 16'h00D0, 1'b0);
    op1(20'h0_0000, 16'h0050);
    op2(SRC_CPU, 16'h0040, 20'h7_E000, 16'h2222, 1'b0);
    op1(20'h0_0000, 16'h0050);
    op2(SRC_SER, 16'h0020, 20'h7_FFFE, 16'h00D0, 1'b0);
    op1(20'h0_0000, 16'h0050);
    op2(SRC_PAR, 16'h0020, 20'h7_FFFE, 16'h00D0, 1'b1);
    chk("arr_boot", bt, 1'b1);
    chk("serial_avail", spa, 1'b0);
    chk("start_mode", smode, START_NORMAL);
    op1(20'h0_0000, 16'hAAFF);
    chk("status_sel", ssel, 1'b0);
    op1(20'h0_0000, 16'h5570);
    chk("status_sel", ssel, 1'b1);
    // back to back zero then one write re-enters rewrite mode
    sel_d = 1'b0;
    sel_wr = 1'b1;
    @(negedge clk_sys_in);
    chk("rewrite", rw, 1'b0);
    sel_d = 1'b1;
    @(negedge clk_sys_in);
    sel_wr = 1'b0;
    chk("rewrite", rw, 1'b1);
    @(negedge clk_sys_in);
    sel(1'b0);
    chk("rewrite", rw, 1'b0);
    test_done();
  end

  initial begin
    repeat (5000) @(posedge clk_sys_in);
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
